// >>> hw/emic_defs.svh
// Offsets, field positions, reset values and timing counts of the metering register bank
`ifndef EMIC_DEFS_SVH
`define EMIC_DEFS_SVH

// Register indexes; byte address is four times the index
`define EMIC_IX_AVG_P1 14'h10d6
`define EMIC_IX_AVG_P2 14'h10d7
`define EMIC_IX_AVG_U 14'h10d8
`define EMIC_IX_AVG_IA 14'h10d9
`define EMIC_IX_AVG_IB 14'h10da
`define EMIC_IX_GAIN_P1 14'h10e8
`define EMIC_IX_GAIN_P2 14'h10e9
`define EMIC_IX_GAIN_U 14'h10ea
`define EMIC_IX_GAIN_IA 14'h10eb
`define EMIC_IX_GAIN_IB 14'h10ec
`define EMIC_IX_OFS_P1 14'h10ed
`define EMIC_IX_OFS_P2 14'h10ee
`define EMIC_IX_BPF 14'h10ef
`define EMIC_IX_PTH_P1 14'h10f4
`define EMIC_IX_NTH_P1 14'h10f5
`define EMIC_IX_PTH_P2 14'h10fa
`define EMIC_IX_NTH_P2 14'h10fb
`define EMIC_IX_ACC_P1 14'h1059
`define EMIC_IX_ACC_P2 14'h105a
`define EMIC_IX_CNT_P1 14'h105b
`define EMIC_IX_CNT_P2 14'h105c
`define EMIC_IX_CTRL1 14'h2878
`define EMIC_IX_CTRL3 14'h287a
`define EMIC_IX_PHC1 14'h287b
`define EMIC_IX_PHC2 14'h287c
`define EMIC_IX_CTRL4 14'h287d
`define EMIC_IX_PULSE 14'h287e
`define EMIC_IX_CRP 14'h287f

// Field positions
`define EMIC_B_SEL_I 5
`define EMIC_B_PROC 4
`define EMIC_B_PHC_EN 6
`define EMIC_B_FUNC2 4
`define EMIC_B_LPF 5
`define EMIC_B_BPF 6
`define EMIC_B_ACC_EN 3
`define EMIC_B_PULSE_EN 4
`define EMIC_B_NOLOAD_EN 5
`define EMIC_B_NL_P1 6
`define EMIC_B_NL_P2 7
`define EMIC_B_PHC_SIGN 7
`define EMIC_B_CRP_P1 7
`define EMIC_B_CRP_P2 6

// Reset values
`define EMIC_RST_W32 32'h0000_0000
`define EMIC_RST_W8 8'h00

// Accumulation rate: metering clock over accumulation frequency
`define EMIC_MCLK_HZ 3276800
`define EMIC_ACC_HZ 12800
`define EMIC_ACC_DIV (`EMIC_MCLK_HZ / `EMIC_ACC_HZ)

`endif

// >>> hw/emic_pkg.sv
// Types shared by the metering register bank
package emic_pkg;
    typedef enum logic [1:0] {
        EMIC_SRC_SIGNED = 2'h0,
        EMIC_SRC_ABS = 2'h1,
        EMIC_SRC_POS = 2'h3,
        EMIC_SRC_NEG = 2'h2
    } emic_src_t;
endpackage : emic_pkg

// >>> hw/emic_regs.sv
// Control and calibration register bank of the energy metering engine
//
// Summary of operation
// - Writing one to processing enable starts power and RMS calculation.
// - Current channel select bit picks the current channel used for metering.
// - Phase compensation enable plus two control registers and creep low bits set delay.
// - Function select bit makes second path compute active or reactive energy.
// - Low-pass and band-pass filter enable bits act independently.
// - Two select bits choose the source of path one's positive accumulator.
// - Bit 5 of control four together with bits 6 and 7 enables no-load detection per path.
// - Accumulators and pulse counters load written values; zero clears them.
// - Phase sign zero delays current, one delays voltage; magnitude gives delay.
// - Thresholds unsigned RW, gains and offsets signed RW, averages signed RO.
// - Accumulation runs at metering clock over 256, e.g. 12800 Hz.
// - Creep bits 7 and 6 show creeping per path, zero while metering.
`timescale 1ns/100ps
`include "emic_defs.svh"

module emic_regs #(
    parameter int ACC_DIV = `EMIC_ACC_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Datapath results and metering clock enable
    input wire logic meterTick,
    input wire logic sampleValid,
    input wire logic [31:0] activePowerOne,
    input wire logic [31:0] activePowerTwo,
    input wire logic [31:0] reactivePowerTwo,
    input wire logic [31:0] voltageRms,
    input wire logic [31:0] currentARms,
    input wire logic [31:0] currentBRms,
    // Datapath controls
    output logic processingEnable,
    output logic [3:0] channelInputEnables,
    output logic currentChannelSelect,
    output logic lowpassEnable,
    output logic bandpassEnable,
    output logic secondPathFunctionSelect,
    output logic [31:0] bandpassParameter,
    output logic delayVoltageOne,
    output logic [7:0] phaseDelayOne,
    output logic delayVoltageTwo,
    output logic [7:0] phaseDelayTwo,
    // Energy pulses
    output logic [1:0] energyPulse
);
    // Divider counter is 16 bits wide and needs at least two states
    if (ACC_DIV < 2 || ACC_DIV > 65535) begin : gBadDiv
        $error("emic_regs: ACC_DIV out of range");
    end

    logic [31:0] avg_r [0:4];
    logic [31:0] gain_r [0:4];
    logic [31:0] ofs_r [0:1];
    logic [31:0] bpf_r;
    logic [31:0] pth_r [0:1];
    logic [31:0] nth_r [0:1];
    logic [31:0] acc_r [0:1];
    logic [31:0] cnt_r [0:1];
    logic [7:0] ctrl1_r, ctrl3_r, phc1_r, phc2_r, ctrl4_r, pulseCtrl_r;
    logic [3:0] crpLow_r;
    logic [1:0] creep_r;
    logic [1:0] pulse_r;
    logic [15:0] div_r;
    logic accTick_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic [13:0] idx;
    logic wrEn;
    logic [32:0] rdHit;
    logic [7:0] ctrl1_nxt, phc1_nxt, phc2_nxt;
    logic [3:0] crpLow_nxt;
    logic delayVoltageOne_r, delayVoltageTwo_r;
    logic [7:0] phaseDelayOne_r, phaseDelayTwo_r;

    assign idx = paddr[15:2];
    // Write lands on the edge at which pready is seen high
    assign wrEn = psel && penable && pready_r && pwrite;

    // Read mux; bit 32 flags a mapped index
    function automatic logic [32:0] rdDecode(input logic [13:0] a);
        case (a)
            `EMIC_IX_AVG_P1: rdDecode = {1'b1, avg_r[0]};
            `EMIC_IX_AVG_P2: rdDecode = {1'b1, avg_r[1]};
            `EMIC_IX_AVG_U: rdDecode = {1'b1, avg_r[2]};
            `EMIC_IX_AVG_IA: rdDecode = {1'b1, avg_r[3]};
            `EMIC_IX_AVG_IB: rdDecode = {1'b1, avg_r[4]};
            `EMIC_IX_GAIN_P1: rdDecode = {1'b1, gain_r[0]};
            `EMIC_IX_GAIN_P2: rdDecode = {1'b1, gain_r[1]};
            `EMIC_IX_GAIN_U: rdDecode = {1'b1, gain_r[2]};
            `EMIC_IX_GAIN_IA: rdDecode = {1'b1, gain_r[3]};
            `EMIC_IX_GAIN_IB: rdDecode = {1'b1, gain_r[4]};
            `EMIC_IX_OFS_P1: rdDecode = {1'b1, ofs_r[0]};
            `EMIC_IX_OFS_P2: rdDecode = {1'b1, ofs_r[1]};
            `EMIC_IX_BPF: rdDecode = {1'b1, bpf_r};
            `EMIC_IX_PTH_P1: rdDecode = {1'b1, pth_r[0]};
            `EMIC_IX_NTH_P1: rdDecode = {1'b1, nth_r[0]};
            `EMIC_IX_PTH_P2: rdDecode = {1'b1, pth_r[1]};
            `EMIC_IX_NTH_P2: rdDecode = {1'b1, nth_r[1]};
            `EMIC_IX_ACC_P1: rdDecode = {1'b1, acc_r[0]};
            `EMIC_IX_ACC_P2: rdDecode = {1'b1, acc_r[1]};
            `EMIC_IX_CNT_P1: rdDecode = {1'b1, cnt_r[0]};
            `EMIC_IX_CNT_P2: rdDecode = {1'b1, cnt_r[1]};
            `EMIC_IX_CTRL1: rdDecode = {1'b1, 24'h000000, ctrl1_r};
            `EMIC_IX_CTRL3: rdDecode = {1'b1, 24'h000000, ctrl3_r};
            `EMIC_IX_PHC1: rdDecode = {1'b1, 24'h000000, phc1_r};
            `EMIC_IX_PHC2: rdDecode = {1'b1, 24'h000000, phc2_r};
            `EMIC_IX_CTRL4: rdDecode = {1'b1, 24'h000000, ctrl4_r};
            `EMIC_IX_PULSE: rdDecode = {1'b1, 24'h000000, pulseCtrl_r};
            `EMIC_IX_CRP: rdDecode = {1'b1, 24'h000000, creep_r, 2'h0, crpLow_r};
            default: rdDecode = {1'b0, 32'h00000000};
        endcase
    endfunction : rdDecode

    // Process form so the mux follows register contents, not only the index
    always_comb begin
        rdHit = rdDecode(idx);
    end

    // One wait state keeps prdata and pready registered
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= `EMIC_RST_W32;
        end else begin
            pready_r <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !rdHit[32];
            prdata_r <= (psel && penable && !pready_r && !pwrite) ? rdHit[31:0] : 32'h00000000;
        end
    end

    // Next values of the registers that steer the phase outputs
    always_comb begin
        ctrl1_nxt = ctrl1_r;
        phc1_nxt = phc1_r;
        phc2_nxt = phc2_r;
        crpLow_nxt = crpLow_r;
        if (wrEn) begin
            case (idx)
                `EMIC_IX_CTRL1: ctrl1_nxt = pwdata[7:0];
                `EMIC_IX_PHC1: phc1_nxt = pwdata[7:0];
                `EMIC_IX_PHC2: phc2_nxt = pwdata[7:0];
                `EMIC_IX_CRP: crpLow_nxt = pwdata[3:0];
                default: ;
            endcase
        end
    end

    // Control registers; all clear at reset so metering starts idle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl1_r <= `EMIC_RST_W8;
            ctrl3_r <= `EMIC_RST_W8;
            phc1_r <= `EMIC_RST_W8;
            phc2_r <= `EMIC_RST_W8;
            ctrl4_r <= `EMIC_RST_W8;
            pulseCtrl_r <= `EMIC_RST_W8;
            crpLow_r <= 4'h0;
        end else begin
            ctrl1_r <= ctrl1_nxt;
            phc1_r <= phc1_nxt;
            phc2_r <= phc2_nxt;
            crpLow_r <= crpLow_nxt;
            if (wrEn) begin
                case (idx)
                    `EMIC_IX_CTRL3: ctrl3_r <= pwdata[7:0];
                    `EMIC_IX_CTRL4: ctrl4_r <= pwdata[7:0];
                    `EMIC_IX_PULSE: pulseCtrl_r <= pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Phase outputs fed from next values, so they move in the cycle of the write
    // Disabled compensation forces zero delay so a stale magnitude cannot leak
    always_ff @(posedge clk) begin
        if (!rstn) begin
            delayVoltageOne_r <= 1'b0;
            delayVoltageTwo_r <= 1'b0;
            phaseDelayOne_r <= 8'h00;
            phaseDelayTwo_r <= 8'h00;
        end else begin
            delayVoltageOne_r <= ctrl1_nxt[`EMIC_B_PHC_EN] & phc1_nxt[`EMIC_B_PHC_SIGN];
            delayVoltageTwo_r <= ctrl1_nxt[`EMIC_B_PHC_EN] & phc2_nxt[`EMIC_B_PHC_SIGN];
            phaseDelayOne_r <= ctrl1_nxt[`EMIC_B_PHC_EN]
                ? {crpLow_nxt[1:0], phc1_nxt[5:0]} : 8'h00;
            phaseDelayTwo_r <= ctrl1_nxt[`EMIC_B_PHC_EN]
                ? {crpLow_nxt[3:2], phc2_nxt[5:0]} : 8'h00;
        end
    end

    // Calibration words, stored as written; signedness is the reader's view
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 5; i++) begin
                gain_r[i] <= `EMIC_RST_W32;
            end
            for (int i = 0; i < 2; i++) begin
                ofs_r[i] <= `EMIC_RST_W32;
                pth_r[i] <= `EMIC_RST_W32;
                nth_r[i] <= `EMIC_RST_W32;
            end
            bpf_r <= `EMIC_RST_W32;
        end else if (wrEn) begin
            case (idx)
                `EMIC_IX_GAIN_P1: gain_r[0] <= pwdata;
                `EMIC_IX_GAIN_P2: gain_r[1] <= pwdata;
                `EMIC_IX_GAIN_U: gain_r[2] <= pwdata;
                `EMIC_IX_GAIN_IA: gain_r[3] <= pwdata;
                `EMIC_IX_GAIN_IB: gain_r[4] <= pwdata;
                `EMIC_IX_OFS_P1: ofs_r[0] <= pwdata;
                `EMIC_IX_OFS_P2: ofs_r[1] <= pwdata;
                `EMIC_IX_BPF: bpf_r <= pwdata;
                `EMIC_IX_PTH_P1: pth_r[0] <= pwdata;
                `EMIC_IX_NTH_P1: nth_r[0] <= pwdata;
                `EMIC_IX_PTH_P2: pth_r[1] <= pwdata;
                `EMIC_IX_NTH_P2: nth_r[1] <= pwdata;
                default: ;
            endcase
        end
    end

    // Averages follow the datapath only while processing runs; writes ignored
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 5; i++) begin
                avg_r[i] <= `EMIC_RST_W32;
            end
        end else if (sampleValid && ctrl1_r[`EMIC_B_PROC]) begin
            avg_r[0] <= activePowerOne;
            avg_r[1] <= ctrl3_r[`EMIC_B_FUNC2] ? reactivePowerTwo : activePowerTwo;
            avg_r[2] <= voltageRms;
            avg_r[3] <= currentARms;
            avg_r[4] <= currentBRms;
        end
    end

    // Accumulation tick from the metering clock enable
    always_ff @(posedge clk) begin
        if (!rstn) begin
            div_r <= 16'h0000;
            accTick_r <= 1'b0;
        end else begin
            accTick_r <= 1'b0;
            if (meterTick) begin
                if (div_r == 16'(ACC_DIV - 1)) begin
                    div_r <= 16'h0000;
                    accTick_r <= 1'b1;
                end else begin
                    div_r <= div_r + 16'h0001;
                end
            end
        end
    end

    // Per-path energy accumulation, pulses and no-load detection
    for (genvar p = 0; p < 2; p++) begin : gPath
        logic signed [32:0] raw;
        logic signed [32:0] src;
        logic [32:0] mag;
        logic [32:0] sum;
        logic noload;
        emic_pkg::emic_src_t sel;

        assign sel = (p == 0) ? emic_pkg::emic_src_t'(ctrl4_r[1:0]) : emic_pkg::EMIC_SRC_POS;
        assign raw = $signed({avg_r[p][31], avg_r[p]}) + $signed({ofs_r[p][31], ofs_r[p]});

        always_comb begin
            case (sel)
                emic_pkg::EMIC_SRC_SIGNED: src = raw;
                emic_pkg::EMIC_SRC_ABS: src = raw[32] ? -raw : raw;
                emic_pkg::EMIC_SRC_POS: src = raw[32] ? 33'sh0 : raw;
                emic_pkg::EMIC_SRC_NEG: src = -raw;
                default: src = 33'sh0;
            endcase
        end

        // Negative contributions never enter the positive accumulator
        assign mag = src[32] ? 33'h0 : src;
        assign sum = {1'b0, acc_r[p]} + mag;
        assign noload = ctrl4_r[`EMIC_B_NOLOAD_EN] && ctrl4_r[`EMIC_B_NL_P1 + p]
            && (mag < {1'b0, nth_r[p]});

        // Software load wins over an accumulation in the same cycle
        always_ff @(posedge clk) begin
            if (!rstn) begin
                acc_r[p] <= `EMIC_RST_W32;
                cnt_r[p] <= `EMIC_RST_W32;
                creep_r[1 - p] <= 1'b0;
                pulse_r[p] <= 1'b0;
            end else begin
                pulse_r[p] <= 1'b0;
                if (accTick_r) begin
                    creep_r[1 - p] <= noload;
                end
                if (wrEn && idx == `EMIC_IX_ACC_P1 + 14'(p)) begin
                    acc_r[p] <= pwdata;
                end else if (accTick_r && ctrl4_r[`EMIC_B_ACC_EN] && !noload) begin
                    if (pth_r[p] != 32'h0 && sum >= {1'b0, pth_r[p]}) begin
                        acc_r[p] <= 32'(sum - {1'b0, pth_r[p]});
                        pulse_r[p] <= ctrl4_r[`EMIC_B_PULSE_EN];
                    end else begin
                        acc_r[p] <= sum[32] ? 32'hffffffff : sum[31:0];
                    end
                end
                if (wrEn && idx == `EMIC_IX_CNT_P1 + 14'(p)) begin
                    cnt_r[p] <= pwdata;
                end else if (accTick_r && ctrl4_r[`EMIC_B_ACC_EN] && !noload
                    && pth_r[p] != 32'h0 && sum >= {1'b0, pth_r[p]}) begin
                    cnt_r[p] <= cnt_r[p] + 32'h1;
                end
            end
        end
    end

    // Outputs
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign processingEnable = ctrl1_r[`EMIC_B_PROC];
    assign channelInputEnables = ctrl1_r[3:0];
    assign currentChannelSelect = ctrl1_r[`EMIC_B_SEL_I];
    assign lowpassEnable = ctrl3_r[`EMIC_B_LPF];
    assign bandpassEnable = ctrl3_r[`EMIC_B_BPF];
    assign secondPathFunctionSelect = ctrl3_r[`EMIC_B_FUNC2];
    assign bandpassParameter = bpf_r;
    assign delayVoltageOne = delayVoltageOne_r;
    assign phaseDelayOne = phaseDelayOne_r;
    assign delayVoltageTwo = delayVoltageTwo_r;
    assign phaseDelayTwo = phaseDelayTwo_r;
    assign energyPulse = pulse_r;
endmodule : emic_regs

// >>> testbench/emic_regs_monitor.sv
// Port checker of the metering register bank
`timescale 1ns/100ps
`include "emic_defs.svh"

module emic_regs_monitor #(
    parameter int ACC_DIV = 4
) (
    // Clock, reset and bus
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Datapath side
    input wire logic processingEnable,
    input wire logic [3:0] channelInputEnables,
    input wire logic currentChannelSelect,
    input wire logic lowpassEnable,
    input wire logic bandpassEnable,
    input wire logic secondPathFunctionSelect,
    input wire logic [31:0] bandpassParameter,
    input wire logic delayVoltageOne,
    input wire logic [7:0] phaseDelayOne,
    input wire logic [1:0] energyPulse
);
    default clocking mcb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic wrDone;
    assign wrDone = psel && penable && pready && pwrite;

    AST_READY_ONE_WAIT:
        assert property (psel && $rose(penable) |=> pready) else $error("no ready after wait");
    AST_READY_PULSE:
        assert property (pready |=> !pready) else $error("ready longer than one cycle");
    AST_ERR_WITH_READY:
        assert property (pslverr |-> pready) else $error("error without ready");
    AST_PRDATA_IDLE:
        assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data not idle");
    AST_CTRL1_FIELDS:
        assert property (wrDone && paddr[15:2] == `EMIC_IX_CTRL1 |=>
            {currentChannelSelect, processingEnable, channelInputEnables} == $past(pwdata[5:0]))
        else $error("control one fields wrong");
    AST_CTRL3_FIELDS:
        assert property (wrDone && paddr[15:2] == `EMIC_IX_CTRL3 |=>
            {bandpassEnable, lowpassEnable, secondPathFunctionSelect} == $past(pwdata[6:4]))
        else $error("control three fields wrong");
    AST_PHASE_STABLE:
        assert property (!wrDone |=> $stable(phaseDelayOne) && $stable(delayVoltageOne))
        else $error("phase output moved without write");
    AST_RESET_CLEAR:
        assert property ($rose(rstn) |-> !processingEnable && channelInputEnables == 4'h0
            && bandpassParameter == 32'h0000_0000 && energyPulse == 2'h0)
        else $error("outputs not cleared by reset");
    AST_PULSE_ONE:
        assert property (energyPulse[0] |=> !energyPulse[0]) else $error("pulse too long");

    COV_ERR: cover property (pslverr);
    COV_CTRL1: cover property (wrDone && paddr[15:2] == `EMIC_IX_CTRL1);
    COV_PULSE: cover property (energyPulse[0]);
endmodule : emic_regs_monitor

bind emic_regs emic_regs_monitor #(.ACC_DIV(ACC_DIV)) emic_regs_monitor_i (.clk, .rstn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .processingEnable,
    .channelInputEnables, .currentChannelSelect, .lowpassEnable, .bandpassEnable,
    .secondPathFunctionSelect, .bandpassParameter, .delayVoltageOne, .phaseDelayOne,
    .energyPulse);

// >>> testbench/energy_metering_init_calibration_tb.sv
// Self-checking bench of the metering register bank
`timescale 1ns/100ps
`include "emic_defs.svh"

module energy_metering_init_calibration_tb;
    localparam int ACC_DIV = 4;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, meterTick = 1'b0, sampleValid = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] activePowerOne = 32'h0000_0064, activePowerTwo = 32'h0000_0007;
    logic [31:0] reactivePowerTwo = 32'hffff_fffb, voltageRms = 32'h0000_0300;
    logic [31:0] currentARms = 32'h0000_0400, currentBRms = 32'h0000_0500;
    logic [31:0] prdata, rdv, bandpassParameter;
    logic pready, pslverr, errv, processingEnable, currentChannelSelect, lowpassEnable;
    logic bandpassEnable, secondPathFunctionSelect, delayVoltageOne, delayVoltageTwo;
    logic [3:0] channelInputEnables;
    logic [7:0] phaseDelayOne, phaseDelayTwo;
    logic [1:0] energyPulse;
    int fails = 0, n_tests = 0, cycles = 0, pulses = 0;

    emic_regs #(.ACC_DIV(ACC_DIV)) emic_regs_i (.clk, .rstn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .meterTick, .sampleValid,
        .activePowerOne, .activePowerTwo, .reactivePowerTwo, .voltageRms, .currentARms,
        .currentBRms, .processingEnable, .channelInputEnables, .currentChannelSelect,
        .lowpassEnable, .bandpassEnable, .secondPathFunctionSelect, .bandpassParameter,
        .delayVoltageOne, .phaseDelayOne, .delayVoltageTwo, .phaseDelayTwo, .energyPulse);

    always #10 clk = ~clk;

    // Hang guard sized well above the whole sequence
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (energyPulse[0] === 1'b1)
            pulses <= pulses + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [13:0] ix, input logic [31:0] wd);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {ix, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // Only the bench timeout ends a wait that never sees pready
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1);
        check("waits", 32'(k), 32'h2);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd(input string what, input logic [13:0] ix, input logic [31:0] exp);
        apb(1'b0, ix, 32'h0);
        check(what, rdv, exp);
    endtask : rd

    // Spaced single-cycle metering ticks, then let pulses land
    task automatic ticks(input int n);
        repeat (n) begin
            meterTick <= 1'b1;
            @(posedge clk);
            meterTick <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask : ticks

    task automatic test_bringup();
        check("procEn", 32'(processingEnable), 32'h0);
        rd("ctrl4", `EMIC_IX_CTRL4, 32'h0);
        apb(1'b1, `EMIC_IX_CTRL4, 32'h0);
        apb(1'b1, `EMIC_IX_CTRL1, 32'h0);
        apb(1'b1, `EMIC_IX_BPF, 32'h8893_74bc);
        check("bpf", bandpassParameter, 32'h8893_74bc);
        apb(1'b1, `EMIC_IX_CTRL1, 32'h10);
        check("procEn", 32'(processingEnable), 32'h1);
        check("chanEn", 32'(channelInputEnables), 32'h0);
    endtask : test_bringup

    task automatic test_fields();
        apb(1'b1, `EMIC_IX_CTRL1, 32'h7f);
        check("chanEn", 32'(channelInputEnables), 32'hf);
        check("current_channel_select", 32'(currentChannelSelect), 32'h1);
        apb(1'b1, `EMIC_IX_CTRL3, 32'h70);
        check("ctrl3", 32'({bandpassEnable, lowpassEnable, secondPathFunctionSelect}), 32'h7);
        apb(1'b1, `EMIC_IX_CTRL3, 32'h30);
        check("ctrl3", 32'({bandpassEnable, lowpassEnable, secondPathFunctionSelect}), 32'h3);
        apb(1'b1, `EMIC_IX_PHC1, 32'h85);
        apb(1'b1, `EMIC_IX_PHC2, 32'h0a);
        apb(1'b1, `EMIC_IX_CRP, 32'hff);
        check("phase1", 32'({delayVoltageOne, phaseDelayOne}), 32'h1c5);
        check("phase2", 32'({delayVoltageTwo, phaseDelayTwo}), 32'h0ca);
        rd("creep", `EMIC_IX_CRP, 32'h0f);
        apb(1'b1, `EMIC_IX_CTRL1, 32'h3f);
        check("phaseOff", 32'({delayVoltageOne, phaseDelayOne}), 32'h0);
    endtask : test_fields

    task automatic test_access();
        logic [13:0] tbl[7] = '{`EMIC_IX_GAIN_P1, `EMIC_IX_GAIN_P2, `EMIC_IX_GAIN_U,
            `EMIC_IX_GAIN_IA, `EMIC_IX_GAIN_IB, `EMIC_IX_OFS_P2, `EMIC_IX_NTH_P2};
        foreach (tbl[i])
            apb(1'b1, tbl[i], 32'h8000_0010 + 32'(i));
        apb(1'b1, `EMIC_IX_PHC1, 32'h85);
        foreach (tbl[i])
            rd("calib", tbl[i], 32'h8000_0010 + 32'(i));
        apb(1'b0, 14'h0000, 32'h0);
        check("unmapped", {errv, rdv[30:0]}, 32'h8000_0000);
        sampleValid <= 1'b1;
        @(posedge clk);
        sampleValid <= 1'b0;
        @(posedge clk);
        apb(1'b1, `EMIC_IX_AVG_P1, 32'h1234);
        rd("avgP1", `EMIC_IX_AVG_P1, 32'h0000_0064);
        rd("avgP2", `EMIC_IX_AVG_P2, 32'hffff_fffb);
        rd("avgU", `EMIC_IX_AVG_U, 32'h0000_0300);
    endtask : test_access

    task automatic test_energy();
        apb(1'b1, `EMIC_IX_ACC_P1, 32'h55);
        rd("acc", `EMIC_IX_ACC_P1, 32'h55);
        apb(1'b1, `EMIC_IX_ACC_P1, 32'h0);
        apb(1'b1, `EMIC_IX_OFS_P1, 32'hffff_fffc);
        apb(1'b1, `EMIC_IX_PTH_P1, 32'd250);
        rd("pth", `EMIC_IX_PTH_P1, 32'd250);
        apb(1'b1, `EMIC_IX_CTRL4, 32'h18);
        // Three accumulations of 96 cross 250 once, leaving 38
        ticks(3 * ACC_DIV);
        check("pulses", 32'(pulses), 32'h1);
        rd("acc", `EMIC_IX_ACC_P1, 32'd38);
        rd("count", `EMIC_IX_CNT_P1, 32'h1);
        apb(1'b1, `EMIC_IX_NTH_P1, 32'd1000);
        apb(1'b1, `EMIC_IX_CTRL4, 32'h78);
        ticks(ACC_DIV);
        rd("creep", `EMIC_IX_CRP, 32'h8f);
        rd("accHeld", `EMIC_IX_ACC_P1, 32'd38);
    endtask : test_energy

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        test_bringup();
        test_fields();
        test_access();
        test_energy();
        stop_test();
    end
endmodule : energy_metering_init_calibration_tb
